// ---- logic/tmr_pkg.sv ----
// Shared constants and types of the 8-bit waveform timer
package tmr_pkg;
   // ----------------------------------------------------------------
   // Register map (word index on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL   = 4'h0; // Mode and clock select
   localparam logic [3:0] ADDR_OUTCFG = 4'h1; // Output actions, pin dirs
   localparam logic [3:0] ADDR_COUNT  = 4'h2; // count_value
   localparam logic [3:0] ADDR_CMPA   = 4'h3; // compare_a_value
   localparam logic [3:0] ADDR_CMPB   = 4'h4; // compare_b_value
   localparam logic [3:0] ADDR_FLAGS  = 4'h5; // Sticky flags, write 1 clears

   // ----------------------------------------------------------------
   // Field layouts and values
   // ----------------------------------------------------------------
   localparam int FLAG_CMPA = 0;              // compare_a_flag bit
   localparam int FLAG_CMPB = 1;              // compare_b_flag bit
   localparam int FLAG_OVF  = 2;              // overflow_flag bit
   localparam logic [7:0] CNT_BOTTOM = 8'h00; // Bottom of the count
   localparam logic [7:0] CNT_MAX    = 8'hFF; // Largest 8-bit count
   localparam logic [7:0] ZERO_BYTE  = 8'h00; // Reset value, idle data
   localparam logic [9:0] DIV_MASK8    = 10'h007; // Prescale factor 8
   localparam logic [9:0] DIV_MASK64   = 10'h03F; // Prescale factor 64
   localparam logic [9:0] DIV_MASK256  = 10'h0FF; // Prescale factor 256
   localparam logic [9:0] DIV_MASK1024 = 10'h3FF; // Prescale factor 1024

   // Output action codes
   localparam logic [1:0] ACT_OFF    = 2'h0; // Pin disconnected
   localparam logic [1:0] ACT_TOGGLE = 2'h1; // Toggle on match
   localparam logic [1:0] ACT_CLEAR  = 2'h2; // Clear (non-inverted PWM)
   localparam logic [1:0] ACT_SET    = 2'h3; // Set (inverted PWM)

   // Waveform modes
   typedef enum logic [2:0] {
      MODE_NORMAL   = 3'h0,
      MODE_PC_MAX   = 3'h1,
      MODE_CTC      = 3'h2,
      MODE_FAST_MAX = 3'h3,
      MODE_RSV4     = 3'h4,
      MODE_PC_CMP   = 3'h5,
      MODE_RSV6     = 3'h6,
      MODE_FAST_CMP = 3'h7
   } tmr_mode_t;

   // Timer clock select
   typedef enum logic [2:0] {
      CLK_STOP    = 3'h0,
      CLK_DIV1    = 3'h1,
      CLK_DIV8    = 3'h2,
      CLK_DIV64   = 3'h3,
      CLK_DIV256  = 3'h4,
      CLK_DIV1024 = 3'h5
   } tmr_clk_sel_t;

   // Control register
   typedef struct packed {
      logic       rsv7;
      logic [2:0] clk_sel;
      logic       rsv3;
      logic [2:0] waveform_mode_sel;
   } tmr_ctrl_t;

   // Output configuration register
   typedef struct packed {
      logic [1:0] rsv;
      logic       dir_b;
      logic       dir_a;
      logic [1:0] output_action_b;
      logic [1:0] output_action_a;
   } tmr_outcfg_t;
endpackage : tmr_pkg

// ---- logic/tmr_wave_timer.sv ----
// Top of the 8-bit timer with clear-on-match and PWM waveform modes
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - Mode 2 clears count on compare A
// - Mode 2 compare A unbuffered, missed match wraps
// - Mode 2 sets compare A flag at top
// - Mode 2 action one toggles output A
// - Pin shows output only when direction out
// - Mode 2 overflow flag on max-to-zero
// - Modes 3, 7 single slope, top per mode
// - Fast PWM clears count after top
// - Fast PWM sets overflow flag at top
// - Fast PWM clear/set on match and wrap
// - PWM toggle of A with mode bit 2
// - Fast PWM extremes give spike or level
// - Fast PWM keeps compare double buffering
// - Modes 1, 5 dual slope, top per mode
// - Phase correct turns at top, one cycle
// - Phase correct sets overflow at bottom
// - Phase correct up/down match actions
// - Phase correct extremes give steady levels
// - Bottom transition without match to up result
// - Count at clock divided 1..1024
// - Compares buffered in PWM, direct otherwise
// - Match sets flag next clock, write-one clears
module tmr_wave_timer (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       sys_rst,
   // Register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_we,
   input  wire logic       reg_re,
   output logic      [7:0] reg_rdata,
   // Waveform pins, enable low while driven
   output logic            wave_out_a,
   output logic            wave_out_a_oe_n,
   output logic            wave_out_b,
   output logic            wave_out_b_oe_n
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   tmr_pkg::tmr_ctrl_t   ctrl_q;          // Mode and clock select
   tmr_pkg::tmr_outcfg_t cfg_q;           // Actions and directions
   logic [7:0]           count_value_q;   // Counter
   logic                 down_q;          // Phase correct direction
   logic                 block_q;         // Match blocked after write
   logic [9:0]           div_q;           // Prescaler count
   logic [2:0]           flags_q;         // Sticky flags
   logic [7:0]           rdata_q;         // Read data
   logic [7:0]           cmp_buf_q [2];   // Software-side compares
   logic [7:0]           cmp_act_q [2];   // Compares in use
   logic [1:0]           wave_q;          // Internal compare states
   logic [1:0]           wave_d;          // Their next values
   logic [1:0]           seen_q;          // Match seen this period
   logic [1:0]           pin_q;           // Pin levels
   logic [1:0]           oe_n_q;          // Pin enables, low drives

   // Decoded helpers
   logic       tick;         // Timer clock enable
   logic       is_fast;      // Single slope PWM
   logic       is_pc;        // Dual slope PWM
   logic       is_ctc;       // Clear on compare A
   logic [7:0] top_val;      // Current top of count
   logic       at_top;       // Counter equals top
   logic       at_bot;       // Counter at bottom
   logic       ovf_ev;       // Overflow event this tick
   logic       load_ev;      // Buffered compare update point
   logic [1:0] match;        // Unblocked compare equality
   logic [1:0] act [2];      // Output actions per channel

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   assign is_ctc  = (ctrl_q.waveform_mode_sel == tmr_pkg::MODE_CTC);
   assign is_fast = (ctrl_q.waveform_mode_sel == tmr_pkg::MODE_FAST_MAX)
                 || (ctrl_q.waveform_mode_sel == tmr_pkg::MODE_FAST_CMP);
   assign is_pc   = (ctrl_q.waveform_mode_sel == tmr_pkg::MODE_PC_MAX)
                 || (ctrl_q.waveform_mode_sel == tmr_pkg::MODE_PC_CMP);
   // Modes 5 and 7 take top from compare A, the rest run to max
   assign top_val = ((ctrl_q.waveform_mode_sel == tmr_pkg::MODE_FAST_CMP)
                 || (ctrl_q.waveform_mode_sel == tmr_pkg::MODE_PC_CMP))
                  ? cmp_act_q[0] : tmr_pkg::CNT_MAX;
   assign at_top  = (count_value_q == top_val);
   assign at_bot  = (count_value_q == tmr_pkg::CNT_BOTTOM);
   assign act[0]  = cfg_q.output_action_a;
   assign act[1]  = cfg_q.output_action_b;
   // Overflow source depends on the count shape
   assign ovf_ev  = is_pc   ? (at_bot && down_q)
                  : is_fast ? at_top
                  : (count_value_q == tmr_pkg::CNT_MAX);
   // Fast PWM loads at the wrap, phase correct at the turn at top
   assign load_ev = tick && at_top && (is_fast || (is_pc && !down_q));
   // ----------------------------------------------------------------
   // Prescaler: free running, tick is one clock wide
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         div_q <= 10'h000;
      end else begin
         div_q <= div_q + 10'h001;
      end
   end
   // Pick the tick; unused codes stop the timer
   always_comb begin
      unique case (ctrl_q.clk_sel)
         tmr_pkg::CLK_STOP:    tick = 1'b0;
         tmr_pkg::CLK_DIV1:    tick = 1'b1;
         tmr_pkg::CLK_DIV8:    tick = ((div_q & tmr_pkg::DIV_MASK8)
                                      == tmr_pkg::DIV_MASK8);
         tmr_pkg::CLK_DIV64:   tick = ((div_q & tmr_pkg::DIV_MASK64)
                                      == tmr_pkg::DIV_MASK64);
         tmr_pkg::CLK_DIV256:  tick = ((div_q & tmr_pkg::DIV_MASK256)
                                      == tmr_pkg::DIV_MASK256);
         tmr_pkg::CLK_DIV1024: tick = (div_q == tmr_pkg::DIV_MASK1024);
         default:              tick = 1'b0;
      endcase
   end
   // ----------------------------------------------------------------
   // Control registers, reserved bits kept at zero
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= '0;
         cfg_q  <= '0;
      end else if (reg_we && reg_addr == tmr_pkg::ADDR_CTRL) begin
         ctrl_q <= tmr_pkg::tmr_ctrl_t'(reg_wdata & 8'h77);
      end else if (reg_we && reg_addr == tmr_pkg::ADDR_OUTCFG) begin
         cfg_q <= tmr_pkg::tmr_outcfg_t'(reg_wdata & 8'h3F);
      end
   end
   // ----------------------------------------------------------------
   // Counter and direction
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         count_value_q <= tmr_pkg::CNT_BOTTOM;
         down_q        <= 1'b0;
      end else if (reg_we && reg_addr == tmr_pkg::ADDR_COUNT) begin
         count_value_q <= reg_wdata;
      end else if (tick) begin
         if (is_pc) begin
            // Top and bottom each last one tick, then turn
            if (!down_q && at_top) begin
               down_q        <= 1'b1;
               count_value_q <= count_value_q - 8'h01;
            end else if (down_q && at_bot) begin
               down_q        <= 1'b0;
               count_value_q <= count_value_q + 8'h01;
            end else if (down_q) begin
               count_value_q <= count_value_q - 8'h01;
            end else begin
               count_value_q <= count_value_q + 8'h01;
            end
         end else if (is_fast && at_top) begin
            count_value_q <= tmr_pkg::CNT_BOTTOM;
         end else if (is_ctc && match[0]) begin
            count_value_q <= tmr_pkg::CNT_BOTTOM;
         end else begin
            // A missed match runs on to max and wraps
            count_value_q <= count_value_q + 8'h01;
         end
      end
   end
   // A counter write masks matches on the next tick, even when stopped
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         block_q <= 1'b0;
      end else if (reg_we && reg_addr == tmr_pkg::ADDR_COUNT) begin
         block_q <= 1'b1;
      end else if (tick) begin
         block_q <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // Sticky flags: hardware set wins over software clear
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flags_q <= 3'h0;
      end else begin
         flags_q <= (flags_q
                  & ~((reg_we && reg_addr == tmr_pkg::ADDR_FLAGS)
                      ? reg_wdata[2:0] : 3'h0))
                  | {tick && ovf_ev, tick && match[1],
                     tick && match[0]};
      end
   end
   // ----------------------------------------------------------------
   // Read port, data valid the cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= tmr_pkg::ZERO_BYTE;
      end else if (reg_re) begin
         unique case (reg_addr)
            tmr_pkg::ADDR_CTRL:   rdata_q <= ctrl_q;
            tmr_pkg::ADDR_OUTCFG: rdata_q <= cfg_q;
            tmr_pkg::ADDR_COUNT:  rdata_q <= count_value_q;
            tmr_pkg::ADDR_CMPA:   rdata_q <= cmp_buf_q[0];
            tmr_pkg::ADDR_CMPB:   rdata_q <= cmp_buf_q[1];
            tmr_pkg::ADDR_FLAGS:  rdata_q <= {5'h00, flags_q};
            default:              rdata_q <= tmr_pkg::ZERO_BYTE;
         endcase
      end else begin
         rdata_q <= tmr_pkg::ZERO_BYTE;
      end
   end
   assign reg_rdata = rdata_q;
   // ----------------------------------------------------------------
   // Compare channels A (0) and B (1)
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_ch
      localparam logic [3:0] ADDR = i ? tmr_pkg::ADDR_CMPB
                                      : tmr_pkg::ADDR_CMPA;
      logic wr;     // Software write to this compare
      logic up_res; // Level after an up-counting match
      logic tog_ok; // Channel A toggle allowed in PWM modes 5 and 7
      assign wr     = reg_we && (reg_addr == ADDR);
      assign up_res = act[i][0];
      assign tog_ok = (i == 0) && ctrl_q.waveform_mode_sel[2];
      assign match[i] = (count_value_q == cmp_act_q[i]) && !block_q;
      // Buffer and active compare; PWM modes defer the update
      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            cmp_buf_q[i] <= tmr_pkg::ZERO_BYTE;
            cmp_act_q[i] <= tmr_pkg::ZERO_BYTE;
         end else begin
            if (wr) begin
               cmp_buf_q[i] <= reg_wdata;
            end
            if (!is_fast && !is_pc) begin
               // Written straight through, no buffering
               if (wr) begin
                  cmp_act_q[i] <= reg_wdata;
               end else begin
                  cmp_act_q[i] <= cmp_buf_q[i];
               end
            end else if (load_ev) begin
               cmp_act_q[i] <= cmp_buf_q[i];
            end
         end
      end
      // Next internal compare state
      always_comb begin
         wave_d[i] = wave_q[i];
         if (tick && is_fast) begin
            if (act[i][1] && at_top) begin
               // Wrap wins, so compare at top gives a steady level
               wave_d[i] = !act[i][0];
            end else if (act[i][1] && match[i]) begin
               wave_d[i] = act[i][0];
            end else if (act[i] == tmr_pkg::ACT_TOGGLE && tog_ok
                         && match[i]) begin
               wave_d[i] = !wave_q[i];
            end
         end else if (tick && is_pc) begin
            if (act[i][1] && !down_q && at_top
                && cmp_act_q[i] >= top_val) begin
               wave_d[i] = !up_res;
            end else if (act[i][1] && match[i]) begin
               // Bottom match counts as the start of the up slope
               wave_d[i] = (!down_q || at_bot) ? up_res
                                               : !up_res;
            end else if (act[i][1] && down_q && at_bot
                         && !seen_q[i] && cmp_act_q[i] != top_val) begin
               wave_d[i] = up_res;
            end else if (act[i] == tmr_pkg::ACT_TOGGLE && tog_ok
                         && match[i]) begin
               wave_d[i] = !wave_q[i];
            end
         end else if (tick && match[i]) begin
            unique case (act[i])
               tmr_pkg::ACT_OFF:    wave_d[i] = wave_q[i];
               tmr_pkg::ACT_TOGGLE: wave_d[i] = !wave_q[i];
               tmr_pkg::ACT_CLEAR:  wave_d[i] = 1'b0;
               tmr_pkg::ACT_SET:    wave_d[i] = 1'b1;
            endcase
         end
      end
      // State, period match memory and pin drivers
      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            wave_q[i] <= 1'b0;
            seen_q[i] <= 1'b0;
            pin_q[i]  <= 1'b0;
            oe_n_q[i] <= 1'b1;
         end else begin
            wave_q[i] <= wave_d[i];
            if (tick && down_q && at_bot) begin
               seen_q[i] <= 1'b0;
            end else if (tick && match[i] && !at_top) begin
               seen_q[i] <= 1'b1;
            end
            pin_q[i]  <= wave_q[i];
            // Driven only with an action chosen and direction out
            oe_n_q[i] <= !((i ? cfg_q.dir_b : cfg_q.dir_a)
                        && act[i] != tmr_pkg::ACT_OFF);
         end
      end
   end
   assign wave_out_a      = pin_q[0];
   assign wave_out_b      = pin_q[1];
   assign wave_out_a_oe_n = oe_n_q[0];
   assign wave_out_b_oe_n = oe_n_q[1];
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_top_up;
      tick && is_pc && !down_q && at_top && !reg_we;
   endsequence
   sequence s_turned;
      down_q && count_value_q == $past(count_value_q) - 8'h01;
   endsequence
   property p_ctc_clear;
      tick && is_ctc && match[0] && !reg_we |=> count_value_q == 8'h00;
   endproperty
   a_ctc_clear: assert property (p_ctc_clear)
      else $error("count not cleared on compare A");
   property p_flag_a;
      tick && match[0] |=> flags_q[tmr_pkg::FLAG_CMPA];
   endproperty
   a_flag_a: assert property (p_flag_a)
      else $error("compare A flag not set");
   property p_ctc_toggle;
      tick && is_ctc && match[0] && act[0] == tmr_pkg::ACT_TOGGLE
         |=> wave_q[0] != $past(wave_q[0]) ##1 pin_q[0] == $past(wave_q[0]);
   endproperty
   a_ctc_toggle: assert property (p_ctc_toggle)
      else $error("output A failed to toggle");
   property p_pin_hidden;
      !cfg_q.dir_a |=> wave_out_a_oe_n;
   endproperty
   a_pin_hidden: assert property (p_pin_hidden)
      else $error("pin A driven with direction in");
   property p_ovf;
      tick && ovf_ev |=> flags_q[tmr_pkg::FLAG_OVF];
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow flag not set");
   property p_fast_wrap;
      tick && is_fast && at_top && !reg_we |=> count_value_q == 8'h00;
   endproperty
   a_fast_wrap: assert property (p_fast_wrap)
      else $error("fast PWM did not wrap at top");
   property p_pc_turn;
      s_top_up |=> s_turned;
   endproperty
   a_pc_turn: assert property (p_pc_turn)
      else $error("phase correct did not turn at top");
   // A new clock select ends the spacing duty, so stopping is legal
   property p_div8;
      tick && ctrl_q.clk_sel == tmr_pkg::CLK_DIV8
         |=> (!tick || ctrl_q.clk_sel != tmr_pkg::CLK_DIV8)[*7]
             ##1 (tick || ctrl_q.clk_sel != tmr_pkg::CLK_DIV8);
   endproperty
   a_div8: assert property (p_div8)
      else $error("divide by 8 tick spacing wrong");
endmodule : tmr_wave_timer

// ---- sim/tmr_load_model.sv ----
// External load seen by the two waveform pins of the timer
`timescale 1ns/1ps

module tmr_load_model (
   // Driven side of the pins
   input  wire logic level_a,
   input  wire logic oe_n_a,
   input  wire logic level_b,
   input  wire logic oe_n_b,
   // Level the load sees
   output logic      pin_a,
   output logic      pin_b
);
   // ------------------------------------------------------------
   // Pin resolution
   // ------------------------------------------------------------
   // A released pin is pulled down by the load resistor, so an
   // undriven pin always reads low, whatever level was last driven
   assign pin_a = (oe_n_a === 1'b0) ? level_a : 1'b0;
   assign pin_b = (oe_n_b === 1'b0) ? level_b : 1'b0;
endmodule : tmr_load_model

// ---- sim/tb_timer8_ctc_and_pwm_modes.sv ----
// Self-checking bench of the waveform timer
`timescale 1ns/1ps

module tb_timer8_ctc_and_pwm_modes;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic       clock = 1'b0;       // 250 MHz system clock
   logic       sys_rst = 1'b1;     // Reset, held at start
   logic [3:0] reg_addr = 4'h0;    // Register index
   logic [7:0] reg_wdata = 8'h00;  // Write data
   logic       reg_we = 1'b0;      // Write strobe
   logic       reg_re = 1'b0;      // Read strobe
   logic [7:0] reg_rdata;          // Read data
   logic       wa, wa_oe_n, wb, wb_oe_n, pin_a, pin_b;
   int         n_mismatch = 0;     // Mismatches seen
   int         comparisons = 0;    // Comparisons made
   int         ha, hb, g, i;
   logic [7:0] d, ca, cb;

   initial begin
      forever #2 clock = ~clock;
   end

   tmr_wave_timer dut (.clock(clock), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(reg_rdata), .wave_out_a(wa),
      .wave_out_a_oe_n(wa_oe_n), .wave_out_b(wb),
      .wave_out_b_oe_n(wb_oe_n));

   tmr_load_model load (.level_a(wa), .oe_n_a(wa_oe_n), .level_b(wb),
      .oe_n_b(wb_oe_n), .pin_a(pin_a), .pin_b(pin_b));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Compare and count
   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One-cycle write strobe
   task wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_we <= 1'b0;
   endtask : wr

   // Read strobe, data taken in the following cycle only
   task rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_re <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   // High cycles on both pins over n cycles
   task high_cnt(input int n);
      ha = 0;
      hb = 0;
      repeat (n) begin
         @(posedge clock);
         #1 ha += (pin_a === 1'b1);
         hb += (pin_b === 1'b1);
      end
   endtask : high_cnt

   // Cycles between two pin A changes, bounded
   task gap;
      logic p;
      int   k;
      #1 p = pin_a;
      k = 0;
      while (pin_a === p && k < 600) begin
         @(posedge clock);
         #1 k++;
      end
      p = pin_a;
      g = 0;
      while (pin_a === p && g < 600) begin
         @(posedge clock);
         #1 g++;
      end
   endtask : gap

   // Stop the timer, clear count and flags
   task halt;
      wr(tmr_pkg::ADDR_CTRL, 8'h00);
      wr(tmr_pkg::ADDR_COUNT, 8'h00);
      wr(tmr_pkg::ADDR_FLAGS, 8'h07);
   endtask : halt

   // Verdict, reached from the sequence or the watchdog
   task complete_run;
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   // ------------------------------------------------------------
   // Watchdog: the sequence needs well under 20k cycles
   // ------------------------------------------------------------
   initial begin
      #200us;
      n_mismatch++;
      complete_run();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      d = 8'($urandom(94));
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      #1 check({wa, wa_oe_n, wb, wb_oe_n}, 16'h5);
      // Reserved bits read zero, unmapped index ignored
      wr(tmr_pkg::ADDR_CTRL, 8'hFF);
      rd(tmr_pkg::ADDR_CTRL, d);
      check(d, 16'h77);
      // Read data stands one cycle only, then returns to zero
      @(posedge clock);
      #1 check(reg_rdata, 16'h00);
      wr(4'hF, 8'h55);
      rd(4'hF, d);
      check(d, 16'h00);
      // Prescale by 8: 80 cycles give about ten ticks
      halt();
      wr(tmr_pkg::ADDR_CTRL, 8'h20);
      repeat (80) @(posedge clock);
      rd(tmr_pkg::ADDR_COUNT, d);
      check(d >= 8'h09 && d <= 8'h0B, 16'h1);
      // Clear-on-match toggle, half period equals compare plus one
      for (i = 0; i < 4; i++) begin
         ca = (i == 0) ? 8'h00 : 8'($urandom % 16);
         halt();
         wr(tmr_pkg::ADDR_CMPA, ca);
         wr(tmr_pkg::ADDR_OUTCFG, 8'h11);
         wr(tmr_pkg::ADDR_CTRL, 8'h12);
         gap();
         check(g, 16'(ca) + 16'h1);
      end
      rd(tmr_pkg::ADDR_FLAGS, d);
      check(d[tmr_pkg::FLAG_CMPA], 16'h1);
      halt();
      rd(tmr_pkg::ADDR_FLAGS, d);
      check(d, 16'h00);
      // Compare below the count: match missed, count wraps
      wr(tmr_pkg::ADDR_COUNT, 8'h10);
      wr(tmr_pkg::ADDR_CMPA, 8'h05);
      wr(tmr_pkg::ADDR_CTRL, 8'h12);
      repeat (100) @(posedge clock);
      rd(tmr_pkg::ADDR_COUNT, d);
      check(d > 8'h10, 16'h1);
      repeat (200) @(posedge clock);
      rd(tmr_pkg::ADDR_FLAGS, d);
      check(d[tmr_pkg::FLAG_OVF], 16'h1);
      // Fast PWM to 0xFF: high time is compare plus one
      for (i = 0; i < 3; i++) begin
         ca = (i == 0) ? 8'h00 : (i == 1) ? 8'($urandom) : 8'hFF;
         cb = 8'($urandom);
         wr(tmr_pkg::ADDR_CMPA, ca);
         wr(tmr_pkg::ADDR_CMPB, cb);
         wr(tmr_pkg::ADDR_OUTCFG, 8'h3A);
         wr(tmr_pkg::ADDR_CTRL, 8'h13);
         wr(tmr_pkg::ADDR_FLAGS, 8'h07);
         repeat (600) @(posedge clock);
         high_cnt(256);
         check(ha, 16'(ca) + 16'h1);
         check(hb, 16'(cb) + 16'h1);
      end
      rd(tmr_pkg::ADDR_FLAGS, d);
      check(d[tmr_pkg::FLAG_OVF], 16'h1);
      // Fast PWM with compare A as top, toggle on match
      halt();
      wr(tmr_pkg::ADDR_CMPA, 8'h09);
      wr(tmr_pkg::ADDR_CMPB, 8'h04);
      wr(tmr_pkg::ADDR_OUTCFG, 8'h35);
      wr(tmr_pkg::ADDR_CTRL, 8'h17);
      gap();
      check(g, 16'hA);
      // Channel B toggle is ignored in PWM: its level must not move
      high_cnt(20);
      check(16'(hb % 20), 16'h0);
      // Phase correct: high time is twice the compare, extremes first;
      // later passes leave max on B without a halt
      halt();
      for (i = 0; i < 3; i++) begin
         ca = (i == 0) ? 8'h00 : 8'($urandom);
         cb = (i == 0) ? 8'hFF : 8'($urandom);
         wr(tmr_pkg::ADDR_CMPA, ca);
         wr(tmr_pkg::ADDR_CMPB, cb);
         wr(tmr_pkg::ADDR_OUTCFG, 8'h3A);
         wr(tmr_pkg::ADDR_CTRL, 8'h11);
         repeat (1100) @(posedge clock);
         wr(tmr_pkg::ADDR_FLAGS, 8'h07);
         high_cnt(510);
         check(ha, 16'(ca) * 16'h2);
         check(hb, 16'(cb) * 16'h2);
      end
      rd(tmr_pkg::ADDR_FLAGS, d);
      check(d[tmr_pkg::FLAG_OVF], 16'h1);
      // Direction bits off: pins released
      wr(tmr_pkg::ADDR_OUTCFG, 8'h0A);
      repeat (3) @(posedge clock);
      #1 check({wa_oe_n, wb_oe_n, pin_a, pin_b}, 16'hC);
      complete_run();
   end
endmodule : tb_timer8_ctc_and_pwm_modes
